// >>> logic/rprc_top.sv
`timescale 1ns/1ps
module rprc_top #(
    parameter int POR_CNT = rprc_pkg::POR_CYCLES,
    parameter int WAIT_CNT = rprc_pkg::HOST_WAIT_CYCLES,
    parameter int SLEEP_DIV = rprc_pkg::SLEEP_DIV_DEFAULT,
    parameter int SETTLE = rprc_pkg::SLEEP_SETTLE_CYCLES
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic SUPPLY_GOOD_I,
    input wire rprc_pkg::rprc_req_s REQ_I,
    output rprc_pkg::rprc_ctl_s CTL_O,
    output logic POR_ACTIVE_O,
    output logic HOST_BUS_READY_O
);
    import rprc_pkg::*;

    logic tick_reg;
    logic [31:0] div_reg;
    logic wlan_req, radio_req;
    logic g1_reg, g2_reg, g3_reg, good_reg;
    logic [31:0] cnt_reg;
    rprc_por_e por_reg;

    // ------------------------------------------------------------
    // Sleep clock tick
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            div_reg <= 32'h0;
            tick_reg <= 1'b0;
        end else if (div_reg == 32'(SLEEP_DIV - 1)) begin
            div_reg <= 32'h0;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 32'h1;
            tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Request filters
    // ------------------------------------------------------------
    rprc_req_filter #(.SETTLE(SETTLE)) u_wlan (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .tick_i(tick_reg),
        .raw_i(REQ_I.wlan_power_request),
        .level_o(wlan_req)
    );

    rprc_req_filter #(.SETTLE(SETTLE)) u_radio (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .tick_i(tick_reg),
        .raw_i(REQ_I.radio_power_request),
        .level_o(radio_req)
    );

    // ------------------------------------------------------------
    // Supply-good synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            g1_reg <= 1'b0;
            g2_reg <= 1'b0;
            g3_reg <= 1'b0;
            good_reg <= 1'b0;
        end else begin
            g1_reg <= SUPPLY_GOOD_I;
            g2_reg <= g1_reg;
            g3_reg <= g2_reg;
            if (g2_reg == g3_reg) begin
                good_reg <= g3_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Power-on reset and host wait
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || !good_reg) begin
            por_reg <= ST_POR;
            cnt_reg <= 32'h0;
        end else begin
            unique case (por_reg)
                ST_POR: begin
                    if (cnt_reg >= 32'(POR_CNT - 1)) begin
                        por_reg <= ST_HOST_WAIT;
                    end
                    cnt_reg <= cnt_reg + 32'h1;
                end
                ST_HOST_WAIT: begin
                    // Wait counted on from POR release
                    if (cnt_reg >= 32'(POR_CNT + WAIT_CNT - 1)) begin
                        por_reg <= ST_READY;
                    end
                    cnt_reg <= cnt_reg + 32'h1;
                end
                ST_READY: begin
                    cnt_reg <= cnt_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            CTL_O <= '{regulator_enable: 1'b0, wlan_reset: 1'b1, radio_reset: 1'b1};
        end else begin
            CTL_O.regulator_enable <= wlan_req | radio_req;
            CTL_O.wlan_reset <= !wlan_req || por_reg == ST_POR;
            CTL_O.radio_reset <= !radio_req || por_reg == ST_POR;
        end
    end

    assign POR_ACTIVE_O = (por_reg == ST_POR);
    assign HOST_BUS_READY_O = (por_reg == ST_READY);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_both_low;
        !wlan_req && !radio_req;
    endsequence

    a_reg_enable_or: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        ##1 CTL_O.regulator_enable == $past(wlan_req | radio_req))
        else $error("regulator enable not OR of requests");

    a_reg_off_both: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        s_both_low ##1 s_both_low |-> !CTL_O.regulator_enable)
        else $error("regulator on with both requests low");

    a_wlan_reset_low: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        !wlan_req |=> CTL_O.wlan_reset)
        else $error("wlan not in reset while request low");

    a_wlan_release: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        wlan_req && por_reg != ST_POR |=> !CTL_O.wlan_reset)
        else $error("wlan held in reset while requested");

    a_radio_reset_low: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        !radio_req && wlan_req |=> CTL_O.radio_reset && CTL_O.regulator_enable)
        else $error("radio released while request low");

    a_por_bound: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        por_reg == ST_POR && good_reg |-> cnt_reg < 32'(POR_CNT))
        else $error("power-on reset held too long");

    a_host_wait_min: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        $rose(HOST_BUS_READY_O) |-> cnt_reg >= 32'(POR_CNT + WAIT_CNT - 1))
        else $error("host bus ready too early");

    a_filter_settle: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        $changed(wlan_req) |-> $past(tick_reg))
        else $error("request changed without a sleep tick");

    // ------------------------------------------------------------
    // Sequencing checks
    // ------------------------------------------------------------
    sequence s_either_high;
        wlan_req || radio_req;
    endsequence

    sequence s_por_leaving;
        good_reg && por_reg == ST_POR && cnt_reg == 32'(POR_CNT - 1);
    endsequence

    sequence s_wait_leaving;
        good_reg && por_reg == ST_HOST_WAIT && cnt_reg == 32'(POR_CNT + WAIT_CNT - 1);
    endsequence

    a_reset_values: assert property (@(posedge CLOCK_I)
        RESET_I |=> !CTL_O.regulator_enable && CTL_O.wlan_reset && CTL_O.radio_reset
            && POR_ACTIVE_O && !HOST_BUS_READY_O)
        else $error("outputs not at reset values");

    a_reg_on_either: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        s_either_high |=> CTL_O.regulator_enable)
        else $error("regulator off with a request high");

    a_radio_release: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        radio_req && por_reg != ST_POR |=> !CTL_O.radio_reset)
        else $error("radio held in reset while requested");

    a_por_holds_resets: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        por_reg == ST_POR |=> CTL_O.wlan_reset && CTL_O.radio_reset)
        else $error("section released during power-on reset");

    a_por_restart: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        !good_reg |=> POR_ACTIVE_O && !HOST_BUS_READY_O)
        else $error("power-on reset not restarted on supply loss");

    a_por_exit: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        s_por_leaving |=> !POR_ACTIVE_O)
        else $error("power-on reset not released at its limit");

    a_por_count: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        $fell(POR_ACTIVE_O) |-> $past(cnt_reg) == 32'(POR_CNT - 1))
        else $error("power-on reset released at wrong count");

    a_good_agree: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        $changed(good_reg) |-> good_reg == $past(g2_reg) && good_reg == $past(g3_reg))
        else $error("supply good taken before stages agree");

    a_wait_exit: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        s_wait_leaving |=> HOST_BUS_READY_O)
        else $error("host bus ready late after wait");

    a_ready_stays: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        HOST_BUS_READY_O && good_reg |=> HOST_BUS_READY_O)
        else $error("host bus ready dropped with supply good");

    a_radio_settle: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        $changed(radio_req) |-> $past(tick_reg))
        else $error("radio request changed without a sleep tick");

    a_tick_single: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        tick_reg |=> !tick_reg)
        else $error("sleep tick longer than one cycle");

endmodule : rprc_top

// >>> logic/rprc_pkg.sv
package rprc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int POR_MAX_MS = 110;
    localparam int HOST_WAIT_MS = 150;
    localparam int NS_PER_MS = 1000000;
    // Longest time rounds down
    localparam int POR_CYCLES = (POR_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;
    // Least time rounds up
    localparam int HOST_WAIT_CYCLES = (HOST_WAIT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_SETTLE_CYCLES = 2;
    localparam int SLEEP_DIV_DEFAULT = 3815;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_REQ_VALUE = 1'b0;

    typedef struct packed {
        logic wlan_power_request;
        logic radio_power_request;
    } rprc_req_s;

    typedef struct packed {
        logic regulator_enable;
        logic wlan_reset;
        logic radio_reset;
    } rprc_ctl_s;

    typedef enum logic [1:0] {
        ST_POR,
        ST_HOST_WAIT,
        ST_READY
    } rprc_por_e;

endpackage : rprc_pkg

// >>> logic/rprc_req_filter.sv
`timescale 1ns/1ps
module rprc_req_filter #(
    parameter int SETTLE = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic raw_i,
    output logic level_o
);
    import rprc_pkg::*;

    logic s1_reg, s2_reg, s3_reg;
    logic [7:0] cnt_reg;

    // ------------------------------------------------------------
    // Three-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg <= RST_REQ_VALUE;
            s2_reg <= RST_REQ_VALUE;
            s3_reg <= RST_REQ_VALUE;
        end else begin
            s1_reg <= raw_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // ------------------------------------------------------------
    // Sleep-tick settle count
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 8'h00;
            level_o <= RST_REQ_VALUE;
        end else if (s2_reg != s3_reg || s3_reg == level_o) begin
            cnt_reg <= 8'h00;
        end else if (tick_i) begin
            if (cnt_reg == 8'(SETTLE - 1)) begin
                level_o <= s3_reg;
                cnt_reg <= 8'h00;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

endmodule : rprc_req_filter

// >>> sim/rprc_host_model.sv
`timescale 1ns/1ps
module rprc_host_model (
    input wire logic clk_i,
    input wire logic wlan_i,
    input wire logic radio_i,
    input wire logic fm_i,
    input wire logic supply_i,
    output rprc_pkg::rprc_req_s req_o,
    output logic supply_good_o
);
    import rprc_pkg::*;
    // ------------------------------------------------------------
    // Host outputs, one clock later than asked
    // ------------------------------------------------------------
    initial begin
        req_o = '0;
        supply_good_o = 1'b0;
    end
    always @(posedge clk_i) begin
        req_o.wlan_power_request <= wlan_i;
        req_o.radio_power_request <= radio_i | fm_i;
        supply_good_o <= supply_i;
    end
endmodule : rprc_host_model

// >>> sim/radio_power_reset_control_bench.sv
`timescale 1ns/1ps
module radio_power_reset_control_bench;
    import rprc_pkg::*;
    logic CLOCK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic wl = 1'b0;
    logic rd = 1'b0;
    logic fm = 1'b0;
    logic sup = 1'b0;
    rprc_req_s req;
    logic good;
    rprc_ctl_s ctl;
    logic por;
    logic rdy;
    int errors = 0;
    int checked = 0;
    int seed = 32'hf6a7;
    logic [2:0] v;
    rprc_ctl_s last;
    always #4 CLOCK_I = ~CLOCK_I;
    rprc_host_model host (.clk_i(CLOCK_I), .wlan_i(wl), .radio_i(rd), .fm_i(fm),
        .supply_i(sup), .req_o(req), .supply_good_o(good));
    rprc_top #(.POR_CNT(20), .WAIT_CNT(30), .SLEEP_DIV(4), .SETTLE(2)) dut (
        .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .SUPPLY_GOOD_I(good), .REQ_I(req),
        .CTL_O(ctl), .POR_ACTIVE_O(por), .HOST_BUS_READY_O(rdy));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task cyc(input int n);
        repeat (n) @(posedge CLOCK_I);
    endtask : cyc
    task look(input int n);
        cyc(n);
        #1;
    endtask : look
    task check(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic rprc_ctl_s exp_ctl(input logic w, input logic r, input logic p);
        exp_ctl = '{regulator_enable: w | r, wlan_reset: ~w | p, radio_reset: ~r | p};
    endfunction : exp_ctl
    task final_report;
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #(8 * 3000);
        errors++;
        final_report();
    end
    initial begin
        cyc(6);
        RESET_I <= 1'b0;
        wl <= 1'b1;
        cyc(2);
        sup <= 1'b1;
        look(20);
        check(por, 1'b1);
        check(ctl, exp_ctl(1'b1, 1'b0, 1'b1));
        look(15);
        check(por, 1'b0);
        check(ctl, exp_ctl(1'b1, 1'b0, 1'b0));
        look(15);
        check(rdy, 1'b0);
        look(15);
        check(rdy, 1'b1);
        for (int i = 0; i < 20; i++) begin
            v = (i < 4) ? i[2:0] : 3'($random(seed));
            last = ctl;
            cyc(1);
            wl <= v[0];
            rd <= v[1];
            fm <= v[2] & v[0];
            look(3);
            check(ctl, last);
            look(30);
            check(ctl, exp_ctl(v[0], v[1] | (v[2] & v[0]), 1'b0));
            cyc(1);
            wl <= ~v[0];
            cyc(1);
            wl <= v[0];
            look(30);
            check(ctl, exp_ctl(v[0], v[1] | (v[2] & v[0]), 1'b0));
        end
        cyc(1);
        wl <= 1'b1;
        rd <= 1'b1;
        look(30);
        cyc(1);
        sup <= 1'b0;
        look(10);
        check({por, rdy, ctl[1:0]}, 4'hB);
        cyc(1);
        RESET_I <= 1'b1;
        look(6);
        check({por, ctl}, 4'hB);
        check(rdy, 1'b0);
        final_report();
    end
endmodule : radio_power_reset_control_bench
